// [src/asp_pkg.sv]
package asp_pkg;
  localparam int DATA_BITS = 8;
  localparam int FIFO_DEPTH = 4;
  localparam int OVERSAMPLE = 16;
  localparam int M2_FAST_DIV = 32;
  localparam int M2_SLOW_DIV = 64;
  localparam logic [1:0] M2_FAST_RELOAD = 2'(M2_FAST_DIV / OVERSAMPLE - 1);
  localparam logic [1:0] M2_SLOW_RELOAD = 2'(M2_SLOW_DIV / OVERSAMPLE - 1);
  localparam logic [3:0] FRAME_M1 = 4'ha;
  localparam logic [3:0] FRAME_M23 = 4'hb;
  localparam logic [3:0] OVS_MID = 4'h7;
  localparam logic [3:0] OVS_LAST = 4'hf;
  localparam logic [3:0] M0_HALF = 4'h6;
  localparam logic [3:0] M0_LAST = 4'hb;
  localparam logic [3:0] M0_LAST_BIT = 4'(DATA_BITS - 1);
  localparam logic [1:0] MODE_SHIFT = 2'h0;
  localparam logic [1:0] MODE_ASYNC8 = 2'h1;
  localparam logic [1:0] MODE_ASYNC9F = 2'h2;
  localparam logic [1:0] MODE_ASYNC9V = 2'h3;
  typedef enum logic [2:0] {
    RX_IDLE = 3'h1,
    RX_START = 3'h2,
    RX_DATA = 3'h4
  } asp_rx_state_t;
endpackage

// [src/asp_fifo_if.sv]
`timescale 1ns/1ns
`default_nettype none
interface asp_fifo_if #(parameter int W = 8);
  logic wrValid;
  logic wrReady;
  logic [W-1:0] wrData;
  logic rdValid;
  logic rdReady;
  logic [W-1:0] rdData;
  modport source(output wrValid, output wrData, input wrReady);
  modport sink(input rdValid, input rdData, output rdReady);
  modport store(input wrValid, input wrData, input rdReady,
                output wrReady, output rdValid, output rdData);
endinterface
`default_nettype wire

// [src/asp_fifo.sv]
`timescale 1ns/1ns
`default_nettype none
// Depth must be a power of two so the pointers wrap on their own.
module asp_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  input wire logic clock,
  input wire logic sys_rst,
  asp_fifo_if.store port
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic notFull;
  } asp_fifo_state_t;

  asp_fifo_state_t q;
  asp_fifo_state_t d;
  logic doWr;
  logic doRd;

  always_comb begin
    d = q;
    doWr = port.wrValid && q.notFull;
    doRd = port.rdReady && (q.cnt != '0);
    if (doWr) begin
      d.mem[q.wp] = port.wrData;
      d.wp = q.wp + 1'b1;
    end
    if (doRd) begin
      d.rp = q.rp + 1'b1;
    end
    if (doWr && !doRd) begin
      d.cnt = q.cnt + 1'b1;
    end else if (doRd && !doWr) begin
      d.cnt = q.cnt - 1'b1;
    end
    d.notFull = (d.cnt != (AW+1)'(D));
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '{notFull: 1'b1, default: '0};
    end else begin
      q <= d;
    end
  end

  assign port.wrReady = q.notFull;
  assign port.rdValid = (q.cnt != '0);
  assign port.rdData = q.mem[q.rp];
endmodule
`default_nettype wire

// [src/asp_serial_port.sv]
`timescale 1ns/1ns
`default_nettype none
module asp_serial_port #(
  parameter int FIFO_DEPTH = asp_pkg::FIFO_DEPTH
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [1:0] modeSel,
  input wire logic rxEnable,
  input wire logic mpEnable,
  input wire logic txNinthBit,
  input wire logic baudSlow,
  input wire logic baudTick,
  input wire logic wrStrobe,
  input wire logic [7:0] wrData,
  input wire logic rxFlagClear,
  input wire logic txFlagClear,
  input wire logic rxdIn,
  output logic wrReady,
  output logic [7:0] rdData,
  output logic rxNinthBit,
  output logic rxFlag,
  output logic txFlag,
  output logic txdOut,
  output logic rxdOut,
  output logic rxdOe
);
  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic rxdPrev;
    logic [1:0] prescale;
    asp_pkg::asp_rx_state_t rxState;
    logic [3:0] rxTick;
    logic [3:0] rxBit;
    logic [9:0] rxShift;
    logic [7:0] rxBuf;
    logic rxNinth;
    logic rxFlag;
    logic txFlag;
    logic txBusy;
    logic m0Rx;
    logic [3:0] txTick;
    logic [3:0] txBit;
    logic [10:0] txShift;
    logic txd;
    logic rxdOut;
    logic rxdOe;
  } asp_port_state_t;

  localparam asp_port_state_t PORT_RESET = '{
    sync1: 1'b1, sync2: 1'b1, rxdPrev: 1'b1, rxState: asp_pkg::RX_IDLE,
    txd: 1'b1, rxdOut: 1'b1, default: '0};

  function automatic logic isNineBit(input logic [1:0] mode);
    isNineBit = (mode == asp_pkg::MODE_ASYNC9F) || (mode == asp_pkg::MODE_ASYNC9V);
  endfunction

  asp_port_state_t q;
  asp_port_state_t d;
  logic tick16;
  logic rxDone;
  logic rxLoad;
  logic m0Load;
  logic m0Start;
  logic txStart;
  logic txDone;
  logic popBuf;
  logic [9:0] nxtShift;
  logic [7:0] rxData;
  logic rxNin;
  logic [3:0] frameLen;

  asp_fifo_if #(.W(8)) bufIf ();

  // ==========================================================================
  // Transmit buffer
  // ==========================================================================
  asp_fifo #(.W(8), .D(FIFO_DEPTH)) txBuffer (
    .clock(clock),
    .sys_rst(sys_rst),
    .port(bufIf.store)
  );

  assign bufIf.wrValid = wrStrobe;
  assign bufIf.wrData = wrData;
  assign bufIf.rdReady = popBuf;

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    d = q;
    tick16 = 1'b0;
    rxDone = 1'b0;
    rxLoad = 1'b0;
    m0Load = 1'b0;
    m0Start = 1'b0;
    txStart = 1'b0;
    txDone = 1'b0;
    popBuf = 1'b0;
    nxtShift = q.rxShift;
    frameLen = isNineBit(modeSel) ? asp_pkg::FRAME_M23 : asp_pkg::FRAME_M1;
    d.sync1 = rxdIn;
    d.sync2 = q.sync1;
    d.rxdPrev = q.sync2;

    // Mode 2 derives its own oversampling tick; modes 1 and 3 use the supplied one.
    if (modeSel == asp_pkg::MODE_ASYNC9F) begin
      if (q.prescale == 2'h0) begin
        tick16 = 1'b1;
        d.prescale = baudSlow ? asp_pkg::M2_SLOW_RELOAD : asp_pkg::M2_FAST_RELOAD;
      end else begin
        d.prescale = q.prescale - 2'h1;
      end
    end else begin
      d.prescale = 2'h0;
      tick16 = baudTick;
    end

    // Asynchronous receiver, independent of the transmitter.
    case (q.rxState)
      asp_pkg::RX_IDLE: begin
        // The pending flag does not hold off a new frame.
        if (modeSel != asp_pkg::MODE_SHIFT && rxEnable && q.rxdPrev && !q.sync2) begin
          d.rxState = asp_pkg::RX_START;
          d.rxTick = 4'h0;
        end
      end
      asp_pkg::RX_START: begin
        if (tick16) begin
          d.rxTick = q.rxTick + 4'h1;
          if (q.rxTick == asp_pkg::OVS_MID) begin
            d.rxTick = 4'h0;
            d.rxBit = 4'h0;
            d.rxState = q.sync2 ? asp_pkg::RX_IDLE : asp_pkg::RX_DATA;
          end
        end
      end
      asp_pkg::RX_DATA: begin
        if (tick16) begin
          d.rxTick = q.rxTick + 4'h1;
          if (q.rxTick == asp_pkg::OVS_LAST) begin
            d.rxTick = 4'h0;
            nxtShift = {q.sync2, q.rxShift[9:1]};
            d.rxShift = nxtShift;
            d.rxBit = q.rxBit + 4'h1;
            if (q.rxBit == frameLen - 4'h2) begin
              d.rxState = asp_pkg::RX_IDLE;
              rxDone = 1'b1;
            end
          end
        end
      end
      default: begin
        d.rxState = asp_pkg::RX_IDLE;
      end
    endcase

    // Mode 1 keeps the stop bit as ninth bit; modes 2 and 3 drop the stop bit.
    rxData = isNineBit(modeSel) ? nxtShift[7:0] : nxtShift[8:1];
    rxNin = isNineBit(modeSel) ? nxtShift[8] : nxtShift[9];
    rxLoad = rxDone && !q.rxFlag && !(isNineBit(modeSel) && mpEnable && !rxNin);

    // Transmitter, which also runs the mode 0 shift sequence in both directions.
    if (!q.txBusy) begin
      if (modeSel == asp_pkg::MODE_SHIFT) begin
        if (bufIf.rdValid) begin
          popBuf = 1'b1;
          txStart = 1'b1;
          d.txBusy = 1'b1;
          d.m0Rx = 1'b0;
          d.txShift = {3'h7, bufIf.rdData};
          d.txTick = 4'h0;
          d.txBit = 4'h0;
          d.txd = 1'b0;
          d.rxdOe = 1'b1;
          d.rxdOut = bufIf.rdData[0];
        end else if (!q.rxFlag && rxEnable) begin
          m0Start = 1'b1;
          d.txBusy = 1'b1;
          d.m0Rx = 1'b1;
          d.txTick = 4'h0;
          d.txBit = 4'h0;
          d.txd = 1'b0;
          d.rxdOe = 1'b0;
        end
      end else if (bufIf.rdValid) begin
        popBuf = 1'b1;
        txStart = 1'b1;
        d.txBusy = 1'b1;
        d.m0Rx = 1'b0;
        d.txShift = {1'b1, isNineBit(modeSel) ? txNinthBit : 1'b1, bufIf.rdData, 1'b0};
        d.txTick = 4'h0;
        d.txBit = 4'h0;
        d.txd = 1'b0;
      end
    end else if (modeSel == asp_pkg::MODE_SHIFT) begin
      d.txTick = q.txTick + 4'h1;
      if (q.m0Rx && q.txTick == asp_pkg::M0_HALF) begin
        d.txShift[7:0] = {q.sync2, q.txShift[7:1]};
      end
      d.txd = (d.txTick >= asp_pkg::M0_HALF);
      if (q.txTick == asp_pkg::M0_LAST) begin
        d.txTick = 4'h0;
        d.txd = 1'b0;
        d.txBit = q.txBit + 4'h1;
        if (!q.m0Rx) begin
          d.txShift = {1'b1, q.txShift[10:1]};
          d.rxdOut = d.txShift[0];
        end
        if (q.txBit == asp_pkg::M0_LAST_BIT) begin
          d.txBusy = 1'b0;
          d.txd = 1'b1;
          d.rxdOe = 1'b0;
          d.rxdOut = 1'b1;
          m0Load = q.m0Rx;
          txDone = !q.m0Rx;
        end
      end
    end else if (tick16) begin
      d.txTick = q.txTick + 4'h1;
      if (q.txTick == asp_pkg::OVS_LAST) begin
        d.txTick = 4'h0;
        d.txShift = {1'b1, q.txShift[10:1]};
        d.txd = d.txShift[0];
        d.txBit = q.txBit + 4'h1;
        if (q.txBit == frameLen - 4'h1) begin
          d.txBusy = 1'b0;
          d.txd = 1'b1;
          txDone = 1'b1;
        end
      end
    end

    if (rxLoad) begin
      d.rxBuf = rxData;
      d.rxNinth = rxNin;
    end else if (m0Load) begin
      d.rxBuf = q.txShift[7:0];
    end
    // A set in the same cycle as a clear wins.
    d.rxFlag = (q.rxFlag && !rxFlagClear) || rxLoad || m0Load;
    d.txFlag = (q.txFlag && !txFlagClear) || txDone;
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      q <= PORT_RESET;
    end else begin
      q <= d;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign wrReady = bufIf.wrReady;
  assign rdData = q.rxBuf;
  assign rxNinthBit = q.rxNinth;
  assign rxFlag = q.rxFlag;
  assign txFlag = q.txFlag;
  assign txdOut = q.txd;
  assign rxdOut = q.rxdOut;
  assign rxdOe = q.rxdOe;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  property p_rx_reg_only_on_load;
    @(posedge clock) disable iff (sys_rst)
      (rdData != $past(rdData)) |-> ($past(rxLoad) || $past(m0Load));
  endproperty
  a_rx_reg_only_on_load: assert property (p_rx_reg_only_on_load)
    else $error("Receive register changed without a completed frame.");

  property p_keep_unread;
    @(posedge clock) disable iff (sys_rst)
      (rxDone && q.rxFlag && !rxFlagClear) |=> $stable(rdData) && rxFlag;
  endproperty
  a_keep_unread: assert property (p_keep_unread)
    else $error("Unread byte was overwritten.");

  property p_m0_clock_low;
    @(posedge clock) disable iff (sys_rst)
      (modeSel == asp_pkg::MODE_SHIFT && q.txBusy && $rose(txdOut)) |->
        $past(txdOut, 6) == 1'b0 && $past(txdOut, 1) == 1'b0;
  endproperty
  a_m0_clock_low: assert property (p_m0_clock_low)
    else $error("Mode 0 shift clock low phase is not six cycles.");

  property p_start_bit;
    @(posedge clock) disable iff (sys_rst)
      (txStart && modeSel != asp_pkg::MODE_SHIFT) |=> !txdOut && q.txBusy;
  endproperty
  a_start_bit: assert property (p_start_bit)
    else $error("Frame did not open with a low start bit.");

  property p_tx_only_from_write;
    @(posedge clock) disable iff (sys_rst)
      txStart |-> bufIf.rdValid && !q.txBusy;
  endproperty
  a_tx_only_from_write: assert property (p_tx_only_from_write)
    else $error("Transmission began without a buffered write.");

  property p_m0_rx_gate;
    @(posedge clock) disable iff (sys_rst)
      m0Start |-> !q.rxFlag && rxEnable ##1 !rxdOe;
  endproperty
  a_m0_rx_gate: assert property (p_m0_rx_gate)
    else $error("Mode 0 reception started while not allowed.");

  property p_async_rx_gate;
    @(posedge clock) disable iff (sys_rst)
      (q.rxState == asp_pkg::RX_IDLE ##1 q.rxState == asp_pkg::RX_START) |->
        $past(rxEnable) && $past(q.rxdPrev) && !$past(q.sync2);
  endproperty
  a_async_rx_gate: assert property (p_async_rx_gate)
    else $error("Reception started without enable or start edge.");

  property p_mp_filter;
    @(posedge clock) disable iff (sys_rst)
      ($rose(rxFlag) && $past(isNineBit(modeSel)) && $past(mpEnable) && $past(rxDone))
        |-> rxNinthBit;
  endproperty
  a_mp_filter: assert property (p_mp_filter)
    else $error("Address filter passed a byte with ninth bit low.");

  property p_flags_sticky;
    @(posedge clock) disable iff (sys_rst)
      (txDone || (q.txFlag && !txFlagClear)) |=> txFlag;
  endproperty
  a_flags_sticky: assert property (p_flags_sticky)
    else $error("Transmit complete flag was lost.");

  property p_rx_set_wins;
    @(posedge clock) disable iff (sys_rst)
      (rxLoad || m0Load) |=> rxFlag;
  endproperty
  a_rx_set_wins: assert property (p_rx_set_wins)
    else $error("Receive complete flag not set after a frame.");
endmodule
`default_nettype wire

// [test/asp_peer_model.sv]
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Far-side serial device driving and watching the two lines.
module asp_peer_model (
  input wire logic clock,
  input wire logic serIn,
  input wire logic dataWire,
  output logic lineOut
);
  initial lineOut = 1'b1;

  // Sends one asynchronous frame, LSB first, then idles high.
  task automatic send_async(input logic [10:0] frame, input int len, input int bitClk);
    for (int i = 0; i < len; i++) begin
      lineOut = frame[i];
      repeat (bitClk) @(posedge clock);
      #10;
    end
    lineOut = 1'b1;
  endtask

  // Samples each bit at its middle; stops at the middle of the stop bit.
  task automatic recv_async(input int len, input int bitClk, output logic [10:0] frame);
    frame = '0;
    @(negedge serIn);
    // Each sample is taken just after an edge, so the line has settled.
    repeat (bitClk / 2) @(posedge clock);
    #10;
    for (int i = 0; i < len; i++) begin
      frame[i] = serIn;
      if (i < len - 1) begin
        repeat (bitClk) @(posedge clock);
        #10;
      end
    end
  endtask

  // Shift mode: a new bit goes out on each falling shift clock.
  task automatic send_m0(input logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      @(negedge serIn);
      #10 lineOut = d[i];
    end
    @(posedge serIn);
    repeat (4) @(posedge clock);
    #10 lineOut = ~d[7];
  endtask

  // Shift mode: the data line is taken on each rising shift clock.
  task automatic recv_m0(output logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      @(posedge serIn);
      d[i] = dataWire;
    end
  endtask
endmodule
`default_nettype wire

// [test/tb_full_duplex_async_serial_port.sv]
`timescale 1ns/1ns
`default_nettype none
module tb_full_duplex_async_serial_port;
  localparam int TICK_DIV = 2;
  localparam int LIMIT = 30000;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [1:0] modeSel = 2'h1;
  logic rxEnable = 1'b0;
  logic mpEnable = 1'b0;
  logic txNinthBit = 1'b0;
  logic baudSlow = 1'b0;
  logic baudTick = 1'b0;
  logic wrStrobe = 1'b0;
  logic [7:0] wrData = 8'h00;
  logic rxFlagClear = 1'b0;
  logic txFlagClear = 1'b0;
  wire logic rxdIn;
  wire logic peerLine;
  logic wrReady, rxNinthBit, rxFlag, txFlag, txdOut, rxdOut, rxdOe;
  logic [7:0] rdData;
  int fail_count = 0;
  int compares = 0;
  int cyc = 0;

  always #50 clock = ~clock;
  // The shared data line: the port wins while it drives.
  assign rxdIn = rxdOe ? rxdOut : peerLine;

  asp_serial_port #(.FIFO_DEPTH(asp_pkg::FIFO_DEPTH)) dut_u (.clock(clock), .sys_rst(sys_rst),
    .modeSel(modeSel), .rxEnable(rxEnable), .mpEnable(mpEnable), .txNinthBit(txNinthBit),
    .baudSlow(baudSlow), .baudTick(baudTick), .wrStrobe(wrStrobe), .wrData(wrData),
    .rxFlagClear(rxFlagClear), .txFlagClear(txFlagClear), .rxdIn(rxdIn), .wrReady(wrReady),
    .rdData(rdData), .rxNinthBit(rxNinthBit), .rxFlag(rxFlag), .txFlag(txFlag),
    .txdOut(txdOut), .rxdOut(rxdOut), .rxdOe(rxdOe));
  asp_peer_model peer_u (.clock(clock), .serIn(txdOut), .dataWire(rxdIn), .lineOut(peerLine));

  always @(posedge clock) begin
    #10 baudTick = (cyc % TICK_DIV == 0);
  end
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      fail_count++;
      finish_test();
    end
  end

  // ==========================================================
  // Helpers.
  task finish_test;
    if (fail_count == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input string nm, input logic [10:0] exp, input logic [10:0] got);
    compares++;
    if (got !== exp) begin
      $display("Error %s expected %h got %h", nm, exp, got);
      fail_count++;
    end
  endtask
  task step(input int n);
    repeat (n) @(posedge clock);
    #10;
  endtask
  task wr(input logic [7:0] d);
    step(1);
    wrStrobe = 1'b1;
    wrData = d;
    step(1);
    wrStrobe = 1'b0;
    step(1);
  endtask
  task clr;
    txFlagClear = 1'b1;
    rxFlagClear = 1'b1;
    step(1);
    txFlagClear = 1'b0;
    rxFlagClear = 1'b0;
    step(1);
  endtask
  task automatic wait_flag(input logic rx, input string nm);
    int n = 0;
    while (((rx ? rxFlag : txFlag) !== 1'b1) && n < 3000) begin
      step(1);
      n++;
    end
    chk(nm, 11'h1, 11'(rx ? rxFlag : txFlag));
  endtask
  function automatic logic [10:0] exp_frame(input logic [1:0] m, input logic [7:0] d,
                                            input logic n);
    exp_frame = (m == asp_pkg::MODE_ASYNC8) ? {2'b01, d, 1'b0} : {1'b1, n, d, 1'b0};
  endfunction
  function automatic int flen(input logic [1:0] m);
    flen = (m == asp_pkg::MODE_ASYNC8) ? 10 : 11;
  endfunction
  function automatic int bit_clk(input logic [1:0] m, input logic s);
    if (m == asp_pkg::MODE_ASYNC9F) bit_clk = s ? asp_pkg::M2_SLOW_DIV : asp_pkg::M2_FAST_DIV;
    else bit_clk = asp_pkg::OVERSAMPLE * TICK_DIV;
  endfunction
  task rx_frame(input logic [7:0] b, input logic nb);
    peer_u.send_async(exp_frame(modeSel, b, nb), flen(modeSel), bit_clk(modeSel, baudSlow));
  endtask
  task count_low(input int n, output int lows);
    lows = 0;
    repeat (n) begin
      step(1);
      if (txdOut !== 1'b1) lows++;
    end
  endtask

  // ==========================================================
  // Main sequence.
  initial begin
    logic [10:0] got;
    logic [7:0] d, e;
    logic [1:0] m;
    logic n, slow, done;
    logic [7:0] q[$];
    int k;
    void'($urandom(91516));
    step(10);
    sys_rst = 1'b0;
    chk("txdOut", 11'h1, 11'(txdOut));
    chk("wrReady", 11'h1, 11'(wrReady));
    chk("rxdOe", 11'h0, 11'(rxdOe));
    step(4);
    rxEnable = 1'b1;
    for (int i = 0; i < 4; i++) begin
      m = (i == 3) ? 2'h3 : ((i == 0) ? 2'h1 : 2'h2);
      slow = (i == 2);
      modeSel = m;
      baudSlow = slow;
      step(2);
      d = 8'($urandom);
      e = 8'($urandom);
      n = 1'($urandom);
      txNinthBit = 1'($urandom);
      fork
        wr(d);
        peer_u.recv_async(flen(m), bit_clk(m, slow), got);
        peer_u.send_async(exp_frame(m, e, n), flen(m), bit_clk(m, slow));
      join
      chk("txFrame", exp_frame(m, d, txNinthBit), got);
      wait_flag(1'b1, "rxFlag");
      chk("rdData", 11'(e), 11'(rdData));
      chk("rxNinthBit", 11'((m == 2'h1) ? 1'b1 : n), 11'(rxNinthBit));
      wait_flag(1'b0, "txFlag");
      step(20);
      chk("txFlagHeld", 11'h1, 11'(txFlag));
      clr;
      chk("flagsClear", 11'h0, 11'({rxFlag, txFlag}));
    end
    d = 8'($urandom);
    e = 8'($urandom);
    rx_frame(d, 1'b1);
    wait_flag(1'b1, "rxFlagA");
    rx_frame(e, 1'b0);
    step(10);
    chk("rdKept", 11'(d), 11'(rdData));
    chk("ninthKept", 11'h1, 11'(rxNinthBit));
    d = 8'($urandom);
    fork
      rx_frame(d, 1'b1);
      begin
        step(100);
        clr;
      end
    join
    wait_flag(1'b1, "rxFlagB");
    chk("rdBuffered", 11'(d), 11'(rdData));
    clr;
    modeSel = 2'h2;
    baudSlow = 1'b0;
    mpEnable = 1'b1;
    step(2);
    rx_frame(d, 1'b0);
    step(20);
    chk("mpDrop", 11'h0, 11'(rxFlag));
    rx_frame(e, 1'b1);
    wait_flag(1'b1, "mpFlag");
    chk("mpData", 11'(e), 11'(rdData));
    clr;
    mpEnable = 1'b0;
    rxEnable = 1'b0;
    rx_frame(d, 1'b0);
    step(20);
    chk("rxOff", 11'h0, 11'(rxFlag));
    done = 1'b0;
    fork
      begin
        while (wrReady === 1'b1 && q.size() < 8) begin
          d = 8'($urandom);
          q.push_back(d);
          wr(d);
        end
        chk("fifoFull", 11'h0, 11'(wrReady));
        wr(8'ha5);
        done = 1'b1;
      end
      begin
        k = 0;
        while (!done || k < q.size()) begin
          peer_u.recv_async(11, asp_pkg::M2_FAST_DIV, got);
          chk("fifoOrder", exp_frame(2'h2, q[k], txNinthBit), got);
          k++;
        end
      end
    join
    chk("rdSeparate", 11'(e), 11'(rdData));
    count_low(400, k);
    chk("noExtraFrame", 11'h0, 11'(k));
    clr;
    modeSel = 2'h0;
    step(2);
    d = 8'($urandom);
    fork
      wr(d);
      peer_u.recv_m0(e);
    join
    chk("m0Tx", 11'(d), 11'(e));
    wait_flag(1'b0, "m0TxFlag");
    chk("m0Release", 11'h0, 11'(rxdOe));
    clr;
    d = 8'($urandom);
    rxEnable = 1'b1;
    peer_u.send_m0(d);
    wait_flag(1'b1, "m0RxFlag");
    chk("m0Rx", 11'(d), 11'(rdData));
    count_low(60, k);
    chk("m0Hold", 11'h0, 11'(k));
    rxEnable = 1'b0;
    // A reset in mid-run drops the pending byte and the receive flag.
    sys_rst = 1'b1;
    step(2);
    sys_rst = 1'b0;
    chk("rstState", 11'h001, 11'({rxFlag, rdData, rxdOe, txdOut}));
    step(4);
    clr;
    finish_test();
  end
endmodule
`default_nettype wire
